// ### core/crcfs_pkg.sv
package crcfs_pkg;
    // ------------------------------------------------------------
    // register byte addresses
    // ------------------------------------------------------------
    localparam logic [4:0] CRCFS_ADR_CONTROL = 5'h00;
    localparam logic [4:0] CRCFS_ADR_BYTE_IN = 5'h04;
    localparam logic [4:0] CRCFS_ADR_DATA = 5'h08;
    localparam logic [4:0] CRCFS_ADR_AUTO = 5'h0c;
    localparam logic [4:0] CRCFS_ADR_COUNT = 5'h10;
    // ------------------------------------------------------------
    // control and auto register fields
    // ------------------------------------------------------------
    localparam int CRCFS_CTL_PNT_LO = 0;
    localparam int CRCFS_CTL_PNT_HI = 1;
    localparam int CRCFS_CTL_INIT = 3;
    localparam int CRCFS_CTL_VAL = 2;
    localparam int CRCFS_CTL_SEL = 4;
    localparam int CRCFS_CTL_BUSY = 7;
    localparam int CRCFS_AUTO_EN = 7;
    localparam logic [7:0] CRCFS_CTL_RESET = 8'h00;
    // ------------------------------------------------------------
    // polynomials, seeds, sector layout
    // ------------------------------------------------------------
    localparam logic [31:0] CRCFS_POLY32 = 32'h04c11db7;
    localparam logic [15:0] CRCFS_POLY16 = 16'h1021;
    localparam logic [31:0] CRCFS_SEED_ZERO = 32'h00000000;
    localparam logic [31:0] CRCFS_SEED_ONES = 32'hffffffff;
    localparam int CRCFS_SECTOR_BYTES = 512;
    localparam int CRCFS_SECTOR_BITS = 9;

    typedef struct packed {
        logic poly_width_select;
        logic init_value_select;
        logic [1:0] result_byte_pointer;
    } crcfs_cfg_t;

    typedef enum logic [2:0] {
        CRCFS_IDLE = 3'b001,
        CRCFS_FETCH = 3'b010,
        CRCFS_FOLD = 3'b100
    } crcfs_state_t;
endpackage

// ### core/crcfs_fold.sv
`timescale 1ns/100ps
`default_nettype none
// one byte folded into the running crc in a single cycle
module crcfs_fold
    import crcfs_pkg::*;
(
    input wire logic [31:0] crc_in,
    input wire logic [7:0] data_in,
    input wire logic wide16,
    output logic [31:0] crc_out
);
    // ------------------------------------------------------------
    // bitwise msb-first step, 16-bit result kept in low half
    // ------------------------------------------------------------
    always_comb
    begin
        logic [31:0] c;
        logic fb;
        c = crc_in;
        fb = 1'b0;
        for (int i = 7; i >= 0; i--)
        begin
            if (wide16)
            begin
                fb = c[15] ^ data_in[i];
                c[15:0] = {c[14:0], 1'b0} ^ (fb ? CRCFS_POLY16 : 16'h0000);
                c[31:16] = 16'h0000;
            end
            else
            begin
                fb = c[31] ^ data_in[i];
                c = {c[30:0], 1'b0} ^ (fb ? CRCFS_POLY32 : 32'h00000000);
            end
        end
        crc_out = c;
    end
endmodule
`default_nettype wire

// ### core/crcfs_top.sv
`timescale 1ns/100ps
`default_nettype none
// crc engine with automatic flash sector scan, wishbone slave
module crcfs_top
    import crcfs_pkg::*;
#(
    parameter int FLASH_AW = 14,
    parameter int PAGE_W = 8,
    parameter int COUNT_W = 8
)
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [4:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic [FLASH_AW-1:0] flash_addr,
    output logic flash_rd,
    input wire logic [7:0] flash_data,
    output logic cpu_stall
);
    // refuse sizes the address build and count load cannot serve
    if (FLASH_AW <= CRCFS_SECTOR_BITS || PAGE_W < 1 || COUNT_W < 1 ||
        COUNT_W > 32)
    begin : g_bad_param
        $error("crcfs_top: unsupported parameters");
    end

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    crcfs_cfg_t cfg_r;
    crcfs_state_t state_r;
    logic [31:0] crc_r;
    logic [PAGE_W-1:0] page_r;
    logic auto_en_r;
    logic [COUNT_W-1:0] count_r;
    logic [COUNT_W-1:0] sectors_left_r;
    logic [FLASH_AW-1:0] addr_r;
    logic [CRCFS_SECTOR_BITS-1:0] byte_cnt_r;
    logic [7:0] fetched_r;
    logic ack_r;
    logic [31:0] dat_r;

    // ------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------
    wire req = wb_cyc_i & wb_stb_i & ~ack_r;
    wire busy = (state_r != CRCFS_IDLE);
    // the held scan-starting write must not act again while busy
    wire wr = req & ~busy & wb_we_i & wb_sel_i[0];
    wire rd = req & ~busy & ~wb_we_i;
    wire wr_ctl = wr & (wb_adr_i == CRCFS_ADR_CONTROL);
    wire wr_in = wr & (wb_adr_i == CRCFS_ADR_BYTE_IN);
    wire wr_dat = wr & (wb_adr_i == CRCFS_ADR_DATA);
    wire wr_auto = wr & (wb_adr_i == CRCFS_ADR_AUTO);
    wire wr_cnt = wr & (wb_adr_i == CRCFS_ADR_COUNT);
    wire rd_dat = rd & (wb_adr_i == CRCFS_ADR_DATA);
    wire [7:0] wbyte = wb_dat_i[7:0];

    // ------------------------------------------------------------
    // seed, pointer and byte selection
    // ------------------------------------------------------------
    wire new_sel = wr_ctl ? wbyte[CRCFS_CTL_SEL] : cfg_r.poly_width_select;
    wire new_val = wr_ctl ? wbyte[CRCFS_CTL_VAL] : cfg_r.init_value_select;
    wire [31:0] seed = new_val ? CRCFS_SEED_ONES : CRCFS_SEED_ZERO;
    wire [31:0] seed_w = new_sel ? {16'h0000, seed[15:0]} : seed;
    wire [1:0] pnt = cfg_r.result_byte_pointer;
    wire [1:0] pnt_last = cfg_r.poly_width_select ? 2'd1 : 2'd3;
    wire [1:0] pnt_inc = (pnt >= pnt_last) ? 2'd0 : pnt + 2'd1;
    wire [7:0] res_byte = crc_r[{pnt, 3'b000} +: 8];
    wire start_auto = wr_ctl & auto_en_r & (count_r != '0);

    // ------------------------------------------------------------
    // fold input: software byte or fetched flash byte
    // ------------------------------------------------------------
    wire fold_scan = (state_r == CRCFS_FOLD);
    wire [7:0] fold_byte = fold_scan ? fetched_r : wbyte;
    logic [31:0] fold_out;

    crcfs_fold u_fold (
        .crc_in(crc_r),
        .data_in(fold_byte),
        .wide16(cfg_r.poly_width_select),
        .crc_out(fold_out)
    );

    // ------------------------------------------------------------
    // result register next value
    // ------------------------------------------------------------
    logic [31:0] crc_nxt;
    always_comb
    begin
        crc_nxt = crc_r;
        if (wr_ctl && wbyte[CRCFS_CTL_INIT])
            crc_nxt = seed_w;
        else if (fold_scan || (wr_in && !busy))
            crc_nxt = fold_out;
        else if (wr_dat && !busy)
            crc_nxt[{pnt, 3'b000} +: 8] = wbyte;
    end

    // ------------------------------------------------------------
    // configuration and result registers
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            cfg_r <= '{CRCFS_CTL_RESET[CRCFS_CTL_SEL],
                       CRCFS_CTL_RESET[CRCFS_CTL_VAL],
                       CRCFS_CTL_RESET[CRCFS_CTL_PNT_HI:CRCFS_CTL_PNT_LO]};
            crc_r <= CRCFS_SEED_ZERO;
        end
        else
        begin
            crc_r <= crc_nxt;
            if (wr_ctl)
                cfg_r <= '{wbyte[CRCFS_CTL_SEL], wbyte[CRCFS_CTL_VAL],
                           wbyte[CRCFS_CTL_PNT_HI:CRCFS_CTL_PNT_LO]};
            else if ((wr_dat || rd_dat) && !busy)
                cfg_r.result_byte_pointer <= pnt_inc;
        end
    end

    // ------------------------------------------------------------
    // auto configuration and sector count
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            page_r <= '0;
            auto_en_r <= 1'b0;
            count_r <= '0;
        end
        else
        begin
            if (wr_auto)
            begin
                page_r <= PAGE_W'(wbyte[6:0]); // enable bit kept out
                auto_en_r <= wbyte[CRCFS_AUTO_EN];
            end
            if (wr_cnt)
                count_r <= wb_dat_i[COUNT_W-1:0];
        end
    end

    // ------------------------------------------------------------
    // scan sequencer: fetch a byte, fold it, 512 per sector
    // ------------------------------------------------------------
    wire last_byte = (byte_cnt_r == 9'(CRCFS_SECTOR_BYTES - 1));
    wire last_sector = (sectors_left_r == COUNT_W'(1));
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            state_r <= CRCFS_IDLE;
            sectors_left_r <= '0;
            addr_r <= '0;
            byte_cnt_r <= '0;
            fetched_r <= 8'h00;
        end
        else
        begin
            unique case (state_r)
                CRCFS_IDLE:
                    if (start_auto)
                    begin
                        state_r <= CRCFS_FETCH;
                        sectors_left_r <= count_r;
                        addr_r <= FLASH_AW'({page_r,
                            {CRCFS_SECTOR_BITS{1'b0}}});
                        byte_cnt_r <= '0;
                    end
                CRCFS_FETCH:
                begin
                    fetched_r <= flash_data;
                    state_r <= CRCFS_FOLD;
                end
                CRCFS_FOLD:
                begin
                    addr_r <= addr_r + FLASH_AW'(1);
                    byte_cnt_r <= byte_cnt_r + 9'd1;
                    state_r <= CRCFS_FETCH;
                    if (last_byte)
                    begin
                        sectors_left_r <= sectors_left_r - COUNT_W'(1);
                        if (last_sector)
                            state_r <= CRCFS_IDLE;
                    end
                end
                default:
                    state_r <= CRCFS_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // read mux and ack, ack held back during a scan
    // ------------------------------------------------------------
    logic [31:0] rd_mux;
    always_comb
    begin
        rd_mux = 32'h00000000;
        unique case (wb_adr_i)
            CRCFS_ADR_CONTROL:
                rd_mux[7:0] = {busy, 2'b00, cfg_r.poly_width_select,
                    1'b0, cfg_r.init_value_select, pnt};
            CRCFS_ADR_DATA: rd_mux[7:0] = res_byte;
            CRCFS_ADR_AUTO: rd_mux[7:0] = {auto_en_r, 7'(page_r)};
            CRCFS_ADR_COUNT: rd_mux[COUNT_W-1:0] = count_r;
            default: rd_mux = 32'h00000000;
        endcase
    end

    wire scan_done = fold_scan & last_byte & last_sector;
    wire ack_nxt = req & (~busy | scan_done) & ~start_auto;
    logic start_pend_r;
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            ack_r <= 1'b0;
            dat_r <= 32'h00000000;
            start_pend_r <= 1'b0;
        end
        else
        begin
            start_pend_r <= start_auto | (start_pend_r & ~scan_done);
            ack_r <= ack_nxt & ~start_pend_r | (start_pend_r & scan_done);
            if (rd)
                dat_r <= rd_mux;
        end
    end

    assign wb_ack_o = ack_r;
    assign wb_dat_o = dat_r;
    assign flash_addr = addr_r;
    assign flash_rd = (state_r == CRCFS_FETCH);
    assign cpu_stall = busy;
endmodule
`default_nettype wire

// ### tb/crcfs_props.sv
`timescale 1ns/100ps
`default_nettype none
// handshake and scan sequencing checks on the top ports
module crcfs_props
    import crcfs_pkg::*;
#(
    parameter int FLASH_AW = 14
)
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic [FLASH_AW-1:0] flash_addr,
    input wire logic flash_rd,
    input wire logic cpu_stall
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);
    // bus answer shape
    chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held past one cycle");
    chk_ack_cause: assert property (wb_ack_o |-> wb_cyc_i && $past(wb_stb_i))
        else $error("ack without request");
    chk_dat_byte: assert property (wb_dat_o[31:8] == 24'h000000)
        else $error("read data above bit 7");
    // scan sequencing
    chk_rd_stall: assert property (flash_rd |-> cpu_stall)
        else $error("flash read outside scan");
    chk_fetch_fold: assert property (flash_rd |=> !flash_rd && cpu_stall)
        else $error("fetch not followed by fold");
    chk_addr_step: assert property (flash_rd ##2 flash_rd |->
        flash_addr == $past(flash_addr, 2) + 1'b1)
        else $error("flash address not ascending");
    chk_scan_start: assert property ($rose(cpu_stall) |->
        flash_rd && flash_addr[8:0] == 9'h000)
        else $error("scan not at sector start");
    chk_scan_end: assert property ($fell(cpu_stall) |-> wb_ack_o)
        else $error("stall ended without ack");
    chk_ack_free: assert property (wb_ack_o |-> !cpu_stall)
        else $error("ack while stalled");
endmodule
`default_nettype wire

// ### tb/crcfs_flash_model.sv
`timescale 1ns/100ps
`default_nettype none
// combinational flash, inverted last byte while not read
module crcfs_flash_model
(
    input wire logic sys_clk,
    input wire logic [13:0] flash_addr,
    input wire logic flash_rd,
    output logic [7:0] flash_data
);
    logic [7:0] last_r;
    assign flash_data = flash_rd ?
        (flash_addr[7:0] ^ flash_addr[13:6] ^ 8'h5a) : ~last_r;
    always_ff @(posedge sys_clk)
        if (flash_rd) last_r <= flash_data;
endmodule
`default_nettype wire

// ### tb/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin \
    error_cnt++; $display("MISMATCH %s exp %h got %h", nm, e, g); end end
module tb_top
    import crcfs_pkg::*;
;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [4:0] adr = 5'h00;
    logic [31:0] dat_i = 32'h0;
    logic [3:0] sel = 4'hf;
    logic [31:0] dat_o;
    logic ack;
    logic [13:0] faddr;
    logic frd;
    logic [7:0] fdata;
    logic stall;
    int error_cnt = 0;
    int checks_done = 0;
    int cycles = 0;
    always #2 sys_clk = ~sys_clk;
    crcfs_top u_crcfs_top(.sys_clk(sys_clk), .rst_n(rst_n), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
        .wb_dat_i(dat_i), .wb_dat_o(dat_o), .wb_ack_o(ack),
        .flash_addr(faddr), .flash_rd(frd), .flash_data(fdata),
        .cpu_stall(stall));
    crcfs_flash_model u_crcfs_flash_model(.sys_clk(sys_clk),
        .flash_addr(faddr), .flash_rd(frd), .flash_data(fdata));
    task automatic summarize();
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // hang guard
    always @(posedge sys_clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            error_cnt++;
            summarize();
        end
    end
    // one classic wishbone cycle, n counts edges up to ack
    task automatic wb(input logic w, input logic [4:0] a,
        input logic [31:0] d, output logic [31:0] q, output int n);
        n = 0;
        @(posedge sys_clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat_i <= d;
        do
        begin
            @(posedge sys_clk);
            n++;
        end
        while (ack !== 1'b1);
        q = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    // msb first reference fold
    function automatic logic [31:0] fold(logic [31:0] c, logic [7:0] d,
        logic w);
        logic fb;
        for (int i = 7; i >= 0; i--)
        begin
            fb = d[i] ^ (w ? c[15] : c[31]);
            c = c << 1;
            if (fb) c = c ^ (w ? {16'h0000, CRCFS_POLY16} : CRCFS_POLY32);
        end
        return w ? {16'h0000, c[15:0]} : c;
    endfunction
    // pointer to 0, read result bytes, then one read past the wrap
    task automatic rd_res(input logic w, output logic [31:0] v);
        logic [31:0] q;
        int n;
        v = 32'h0;
        wb(1'b1, CRCFS_ADR_CONTROL, {27'h0, w, 4'h0}, q, n);
        for (int i = 0; i < (w ? 3 : 5); i++)
        begin
            wb(1'b0, CRCFS_ADR_DATA, 32'h0, q, n);
            if (i < (w ? 2 : 4)) v[8*i +: 8] = q[7:0];
            else `CHK("wrap", v[7:0], q[7:0])
        end
    endtask
    initial
    begin
        logic [31:0] q;
        logic [31:0] e;
        logic [31:0] g;
        logic w;
        int n;
        repeat (16) @(posedge sys_clk);
        rst_n <= 1'b1;
        wb(1'b0, CRCFS_ADR_CONTROL, 32'h0, q, n);
        `CHK("ctl_reset", 32'h0, q)
        wb(1'b0, 5'h14, 32'h0, q, n);
        `CHK("unmapped", 32'h0, q)
        // every width and seed, seed then three bytes
        for (int m = 0; m < 4; m++)
        begin
            w = m[1];
            wb(1'b1, CRCFS_ADR_CONTROL, {27'h0, w, 1'b1, m[0], 2'b00}, q, n);
            e = m[0] ? CRCFS_SEED_ONES : CRCFS_SEED_ZERO;
            if (w) e = {16'h0000, e[15:0]};
            rd_res(w, g);
            `CHK("seed", e, g)
            for (int i = 0; i < 3; i++)
            begin
                wb(1'b1, CRCFS_ADR_BYTE_IN, {24'h0, 8'h31 ^ 8'(i * 99)}, q, n);
                e = fold(e, 8'h31 ^ 8'(i * 99), w);
            end
            rd_res(w, g);
            `CHK("crc", e, g)
        end
        // overwrite through data port, then one more byte
        wb(1'b1, CRCFS_ADR_CONTROL, 32'h0, q, n);
        for (int i = 1; i < 5; i++)
            wb(1'b1, CRCFS_ADR_DATA, 32'(i * 17), q, n);
        rd_res(1'b0, g);
        `CHK("overwrite", 32'h44332211, g)
        wb(1'b1, CRCFS_ADR_BYTE_IN, 32'h000000a5, q, n);
        rd_res(1'b0, g);
        `CHK("after_ow", fold(32'h44332211, 8'ha5, 1'b0), g)
        // byte write with lane 0 off must leave the result alone
        sel <= 4'he;
        wb(1'b1, CRCFS_ADR_BYTE_IN, 32'h0000005a, q, n);
        sel <= 4'hf;
        rd_res(1'b0, g);
        `CHK("sel_off", fold(32'h44332211, 8'ha5, 1'b0), g)
        // one sector scan from page 3
        wb(1'b1, CRCFS_ADR_CONTROL, 32'h0000000c, q, n);
        wb(1'b1, CRCFS_ADR_AUTO, 32'h00000083, q, n);
        wb(1'b1, CRCFS_ADR_COUNT, 32'h00000001, q, n);
        wb(1'b1, CRCFS_ADR_CONTROL, 32'h0, q, n);
        `CHK("scan_len", 1026, n)
        wb(1'b1, CRCFS_ADR_AUTO, 32'h0, q, n);
        e = CRCFS_SEED_ONES;
        for (int a = 1536; a < 2048; a++)
            e = fold(e, 8'(a) ^ 8'(a >> 6) ^ 8'h5a, 1'b0);
        rd_res(1'b0, g);
        `CHK("scan_crc", e, g)
        summarize();
    end
endmodule
bind crcfs_top crcfs_props #(.FLASH_AW(FLASH_AW)) u_crcfs_props(
    .sys_clk(sys_clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .flash_addr(flash_addr), .flash_rd(flash_rd), .cpu_stall(cpu_stall));
`default_nettype wire
